// >>> design/pmb_pkg.sv
package pmb_pkg;
    // ****************************************************************
    // widths and depths
    // ****************************************************************
    localparam int ADDR_W = 24;
    localparam int PCIE_W = 128;
    localparam int LOCAL_W = 256;
    localparam int CMD_W = ADDR_W + 1;
    localparam int CMD_WRITE_BIT = ADDR_W;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] FIFO_FULL = 3'h4;

    // ****************************************************************
    // variant figures
    // ****************************************************************
    // two words per DDR2 local write
    localparam logic [CNT_W-1:0] WORDS_DDR2 = 3'h2;
    // four words per DDR3 local write
    localparam logic [CNT_W-1:0] WORDS_DDR3 = 3'h4;
    localparam logic [1:0] BEATS_DDR2 = 2'h1;
    localparam logic [1:0] BEATS_DDR3 = 2'h2;
    // memory data per edge and burst length
    localparam int MEM_EDGE_BITS = 64;
    localparam int BURST_DDR3 = 8;
    localparam int BURST_DDR2 = 4;
    localparam int LOCAL_KHZ_DDR3 = 266667;
    localparam int LOCAL_KHZ_DDR2 = 150000;
    localparam int APP_KHZ_GEN2 = 250000;
    localparam int APP_KHZ_GEN1 = 125000;
    localparam int CLK_KHZ = 20000;

    // ****************************************************************
    // control states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_READ = 3'b010,
        ST_GATHER = 3'b011,
        ST_WRITE = 3'b100,
        ST_WRITE2 = 3'b101
    } pmb_state_t;
endpackage

// >>> design/pmb_if.sv
// ********************************************************************
// link between requester and bridge
// ********************************************************************
interface pmb_if;
    logic cmd_valid;
    logic cmd_ready;
    logic cmd_write;
    logic [pmb_pkg::ADDR_W-1:0] cmd_addr;
    logic wd_valid;
    logic wd_ready;
    logic [pmb_pkg::PCIE_W-1:0] wd_data;
    logic rd_valid;
    logic rd_ready;
    logic [pmb_pkg::LOCAL_W-1:0] rd_data;

    modport bridge (
        input cmd_valid, cmd_write, cmd_addr, wd_valid, wd_data, rd_ready,
        output cmd_ready, wd_ready, rd_valid, rd_data
    );
    modport requester (
        output cmd_valid, cmd_write, cmd_addr, wd_valid, wd_data, rd_ready,
        input cmd_ready, wd_ready, rd_valid, rd_data
    );
endinterface

// >>> design/pmb_requester.sv
module pmb_requester #(
    parameter bit P_DDR3 = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    pmb_if.requester link,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [pmb_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [pmb_pkg::PCIE_W-1:0] i_req_data,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [pmb_pkg::LOCAL_W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    typedef struct packed {
        logic [pmb_pkg::CNT_W-1:0] gcnt;
        logic [pmb_pkg::ADDR_W-1:0] base;
    } pmb_req_st_t;

    pmb_req_st_t r_reg;
    pmb_req_st_t r_next;
    logic [pmb_pkg::CNT_W-1:0] words;
    logic [pmb_pkg::ADDR_W-1:0] mask;
    logic take;

    // group size for the variant
    assign words = P_DDR3 ? pmb_pkg::WORDS_DDR3 : pmb_pkg::WORDS_DDR2;
    assign mask = pmb_pkg::ADDR_W'(words - 3'h1);

    // ****************************************************************
    // command and data issue
    // ****************************************************************
    always_comb
    begin
        r_next = r_reg;
        // reads only between write groups
        if (i_req_write)
            o_req_ready = link.cmd_ready && link.wd_ready;
        else
            o_req_ready = link.cmd_ready && (r_reg.gcnt == 3'h0);
        take = i_req_valid && o_req_ready;
        link.cmd_valid = i_req_valid && o_req_ready;
        link.wd_valid = take && i_req_write;
        link.cmd_write = i_req_write;
        link.wd_data = i_req_data;
        if (!i_req_write)
            link.cmd_addr = i_req_addr;
        else if (r_reg.gcnt == 3'h0)
            link.cmd_addr = i_req_addr & ~mask;
        else
            link.cmd_addr = r_reg.base + pmb_pkg::ADDR_W'(r_reg.gcnt);
        if (take && i_req_write)
        begin
            if (r_reg.gcnt == 3'h0)
                r_next.base = i_req_addr & ~mask;
            if (r_reg.gcnt + 3'h1 == words)
                r_next.gcnt = 3'h0;
            else
                r_next.gcnt = r_reg.gcnt + 3'h1;
        end
    end

    // read data passes straight to the user
    assign o_rd_valid = link.rd_valid;
    assign o_rd_data = link.rd_data;
    assign link.rd_ready = i_rd_ready;

    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end
endmodule

// >>> design/pmb_bridge.sv
module pmb_bridge #(
    parameter bit P_DDR3 = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_reset,
    pmb_if.bridge link,
    input wire logic i_mem_ready,
    output logic o_mem_read,
    output logic o_mem_write,
    output logic o_mem_burst_begin,
    output logic [1:0] o_mem_size,
    output logic [pmb_pkg::ADDR_W-1:0] o_mem_addr,
    output logic [pmb_pkg::LOCAL_W-1:0] o_mem_wdata,
    input wire logic i_mem_rdata_valid,
    input wire logic [pmb_pkg::LOCAL_W-1:0] i_mem_rdata
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        pmb_pkg::pmb_state_t state;
        logic [pmb_pkg::FIFO_DEPTH-1:0][pmb_pkg::CMD_W-1:0] cmd_mem;
        logic [pmb_pkg::PTR_W-1:0] cmd_wp;
        logic [pmb_pkg::PTR_W-1:0] cmd_rp;
        logic [pmb_pkg::CNT_W-1:0] cmd_cnt;
        logic [pmb_pkg::FIFO_DEPTH-1:0][pmb_pkg::PCIE_W-1:0] wd_mem;
        logic [pmb_pkg::PTR_W-1:0] wd_wp;
        logic [pmb_pkg::PTR_W-1:0] wd_rp;
        logic [pmb_pkg::CNT_W-1:0] wd_cnt;
        logic [pmb_pkg::FIFO_DEPTH-1:0][pmb_pkg::LOCAL_W-1:0] rd_mem;
        logic [pmb_pkg::PTR_W-1:0] rd_wp;
        logic [pmb_pkg::PTR_W-1:0] rd_rp;
        logic [pmb_pkg::CNT_W-1:0] rd_cnt;
        logic cur_write;
        logic [pmb_pkg::ADDR_W-1:0] cur_addr;
        logic [pmb_pkg::ADDR_W-1:0] base_addr;
        logic [3:0][pmb_pkg::PCIE_W-1:0] gather;
        logic [pmb_pkg::CNT_W-1:0] gcnt;
        logic [pmb_pkg::CNT_W-1:0] outst;
    } pmb_bridge_st_t;

    pmb_bridge_st_t r_reg;
    pmb_bridge_st_t r_next;
    logic [pmb_pkg::CNT_W-1:0] words;
    logic [1:0] beats;
    logic cmd_push;
    logic cmd_pop;
    logic wd_push;
    logic wd_pop;
    logic rd_push;
    logic rd_pop;
    logic rd_room;
    logic [pmb_pkg::CMD_W-1:0] cmd_head;

    // fill level after a push and a pop
    function automatic logic [pmb_pkg::CNT_W-1:0] fifo_level(
        input logic [pmb_pkg::CNT_W-1:0] cnt,
        input logic push,
        input logic pop
    );
        logic [pmb_pkg::CNT_W-1:0] lvl;
        lvl = cnt;
        if (push && !pop)
            lvl = cnt + 3'h1;
        else if (pop && !push)
            lvl = cnt - 3'h1;
        return lvl;
    endfunction

    // variant figures
    assign words = P_DDR3 ? pmb_pkg::WORDS_DDR3 : pmb_pkg::WORDS_DDR2;
    assign beats = P_DDR3 ? pmb_pkg::BEATS_DDR3 : pmb_pkg::BEATS_DDR2;

    // ****************************************************************
    // fifo handshakes
    // ****************************************************************
    // three separate fifos
    assign link.cmd_ready = r_reg.cmd_cnt != pmb_pkg::FIFO_FULL;
    assign link.wd_ready = r_reg.wd_cnt != pmb_pkg::FIFO_FULL;
    assign link.rd_valid = r_reg.rd_cnt != 3'h0;
    assign link.rd_data = r_reg.rd_mem[r_reg.rd_rp];
    assign cmd_push = link.cmd_valid && link.cmd_ready;
    assign wd_push = link.wd_valid && link.wd_ready;
    assign rd_pop = link.rd_valid && link.rd_ready;
    assign rd_push = i_mem_rdata_valid;
    assign cmd_head = r_reg.cmd_mem[r_reg.cmd_rp];
    // read issued only when its return fits
    assign rd_room = (4'(r_reg.rd_cnt) + 4'(r_reg.outst) + 4'(beats))
        <= 4'(pmb_pkg::FIFO_FULL);

    // ****************************************************************
    // control state machine
    // ****************************************************************
    always_comb
    begin
        r_next = r_reg;
        cmd_pop = 1'b0;
        wd_pop = 1'b0;
        o_mem_read = 1'b0;
        o_mem_write = 1'b0;
        o_mem_burst_begin = 1'b0;
        unique case (r_reg.state)
            pmb_pkg::ST_IDLE:
            begin
                if (r_reg.cmd_cnt != 3'h0)
                begin
                    cmd_pop = 1'b1;
                    r_next.cur_write = cmd_head[pmb_pkg::CMD_WRITE_BIT];
                    r_next.cur_addr = cmd_head[pmb_pkg::ADDR_W-1:0];
                    r_next.state = pmb_pkg::ST_DECODE;
                end
            end
            pmb_pkg::ST_DECODE:
            begin
                if (r_reg.cur_write)
                begin
                    if (r_reg.gcnt == 3'h0)
                        r_next.base_addr = r_reg.cur_addr;
                    r_next.state = pmb_pkg::ST_GATHER;
                end
                else
                    r_next.state = pmb_pkg::ST_READ;
            end
            pmb_pkg::ST_READ:
            begin
                if (i_mem_ready && rd_room)
                begin
                    o_mem_read = 1'b1;
                    o_mem_burst_begin = 1'b1;
                    r_next.outst = r_reg.outst + 3'(beats);
                    r_next.state = pmb_pkg::ST_IDLE;
                end
            end
            pmb_pkg::ST_GATHER:
            begin
                if (r_reg.wd_cnt != 3'h0)
                begin
                    wd_pop = 1'b1;
                    r_next.gather[r_reg.gcnt[1:0]] = r_reg.wd_mem[r_reg.wd_rp];
                    r_next.gcnt = r_reg.gcnt + 3'h1;
                    if (r_reg.gcnt + 3'h1 == words)
                        r_next.state = pmb_pkg::ST_WRITE;
                    else
                        r_next.state = pmb_pkg::ST_IDLE;
                end
            end
            pmb_pkg::ST_WRITE:
            begin
                if (i_mem_ready)
                begin
                    o_mem_write = 1'b1;
                    o_mem_burst_begin = 1'b1;
                    if (P_DDR3)
                        r_next.state = pmb_pkg::ST_WRITE2;
                    else
                    begin
                        r_next.gcnt = 3'h0;
                        r_next.state = pmb_pkg::ST_IDLE;
                    end
                end
            end
            pmb_pkg::ST_WRITE2:
            begin
                // second beat on the next cycle
                o_mem_write = 1'b1;
                r_next.gcnt = 3'h0;
                r_next.state = pmb_pkg::ST_IDLE;
            end
            default:
                r_next.state = pmb_pkg::ST_IDLE;
        endcase

        if (cmd_push)
        begin
            r_next.cmd_mem[r_reg.cmd_wp] = {link.cmd_write, link.cmd_addr};
            r_next.cmd_wp = r_reg.cmd_wp + 2'h1;
        end
        if (cmd_pop)
            r_next.cmd_rp = r_reg.cmd_rp + 2'h1;
        r_next.cmd_cnt = fifo_level(r_reg.cmd_cnt, cmd_push, cmd_pop);
        if (wd_push)
        begin
            r_next.wd_mem[r_reg.wd_wp] = link.wd_data;
            r_next.wd_wp = r_reg.wd_wp + 2'h1;
        end
        if (wd_pop)
            r_next.wd_rp = r_reg.wd_rp + 2'h1;
        r_next.wd_cnt = fifo_level(r_reg.wd_cnt, wd_push, wd_pop);
        if (rd_push)
        begin
            r_next.rd_mem[r_reg.rd_wp] = i_mem_rdata;
            r_next.rd_wp = r_reg.rd_wp + 2'h1;
            r_next.outst = r_next.outst - 3'h1;
        end
        if (rd_pop)
            r_next.rd_rp = r_reg.rd_rp + 2'h1;
        r_next.rd_cnt = fifo_level(r_reg.rd_cnt, rd_push, rd_pop);
    end

    // ****************************************************************
    // local interface outputs
    // ****************************************************************
    // local word address and burst size
    assign o_mem_size = beats;
    assign o_mem_addr = r_reg.cur_write ? (r_reg.base_addr >> 1) : (r_reg.cur_addr >> 1);
    // low pair on first beat, high pair on second
    assign o_mem_wdata = (r_reg.state == pmb_pkg::ST_WRITE2) ?
        {r_reg.gather[3], r_reg.gather[2]} : {r_reg.gather[1], r_reg.gather[0]};

    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end
endmodule

// >>> sim/pmb_monitor.sv
module pmb_monitor (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_rd_valid,
    input wire logic i_mem_ready,
    input wire logic i_mem_read,
    input wire logic i_mem_write,
    input wire logic i_mem_burst_begin,
    input wire logic [1:0] i_mem_size,
    input wire logic [pmb_pkg::ADDR_W-1:0] i_mem_addr,
    input wire logic i_mem_rdata_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // ****************************************************************
    // local interface strobes
    // ****************************************************************
    // second beat then release
    sequence s_two_beats;
        i_mem_write ##1 !i_mem_write;
    endsequence
    a_write_two_beats:
        assert property ($rose(i_mem_write) |=> s_two_beats) else $error("write not two beats");
    a_read_needs_ready:
        assert property (i_mem_read |-> i_mem_ready) else $error("read without ready");
    a_read_one_cycle:
        assert property (i_mem_read |=> !i_mem_read) else $error("read strobe too long");
    a_write_needs_ready:
        assert property ($rose(i_mem_write) |-> i_mem_ready && i_mem_burst_begin)
        else $error("write start wrong");
    a_burst_marks_start:
        assert property (i_mem_burst_begin |-> i_mem_read || (i_mem_write && !$past(i_mem_write)))
        else $error("burst begin misplaced");
    a_size_two_beats:
        assert property (i_mem_size == 2'h2) else $error("burst size wrong");
    a_addr_held:
        assert property ($rose(i_mem_write) |=> $stable(i_mem_addr)) else $error("addr moved");
    a_group_aligned:
        assert property ($rose(i_mem_write) |-> !i_mem_addr[0]) else $error("group misaligned");
    a_return_queued:
        assert property (i_mem_rdata_valid |=> i_rd_valid) else $error("return not queued");
endmodule

// >>> sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [23:0] addr; logic [127:0] w0; logic [23:0] laddr;} pmb_row_t;

    // ****************************************************************
    // signals
    // ****************************************************************
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [23:0] req_addr = 24'h0;
    logic [127:0] req_data = 128'h0;
    logic rd_ready = 1'b1;
    logic mem_ready = 1'b1;
    logic rdata_valid = 1'b0;
    logic [255:0] rdata = 256'h0;
    logic req2_valid = 1'b0;
    logic rdata2_valid = 1'b0;
    logic [255:0] rdata2 = 256'h0;
    logic req2_ready, rd2_valid, mem2_read, mem2_write, mem2_bb;
    logic [1:0] mem2_size;
    logic [23:0] mem2_addr;
    logic [255:0] mem2_wdata, rd2_data;
    logic req_ready, rd_valid, mem_read, mem_write, mem_bb;
    logic [1:0] mem_size;
    logic [23:0] mem_addr, waddr, raddr;
    logic [255:0] mem_wdata, rd_data;
    logic [255:0] mem [logic [23:0]];
    logic [255:0] rq[$];
    logic [255:0] got[$];
    logic [255:0] mem2 [logic [23:0]];
    logic [255:0] rq2[$];
    logic [255:0] got2[$];
    int wcnt2 = 0;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    pmb_row_t rows [3] = '{'{24'h0, 128'h1, 24'h0}, '{24'h4, 128'hA5A5, 24'h2},
        '{24'hFFFFFC, 128'hFFF0, 24'h7FFFFE}};

    pmb_if link();
    pmb_requester i_pmb_requester (.i_clk(i_clk), .i_reset(i_reset), .link(link),
        .i_req_valid(req_valid), .i_req_write(req_write), .i_req_addr(req_addr),
        .i_req_data(req_data), .o_req_ready(req_ready), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .i_rd_ready(rd_ready));
    pmb_bridge i_pmb_bridge (.i_clk(i_clk), .i_reset(i_reset), .link(link),
        .i_mem_ready(mem_ready), .o_mem_read(mem_read), .o_mem_write(mem_write),
        .o_mem_burst_begin(mem_bb), .o_mem_size(mem_size), .o_mem_addr(mem_addr),
        .o_mem_wdata(mem_wdata), .i_mem_rdata_valid(rdata_valid), .i_mem_rdata(rdata));
    pmb_monitor i_pmb_monitor (.i_clk(i_clk), .i_reset(i_reset), .i_rd_valid(link.rd_valid),
        .i_mem_ready(mem_ready), .i_mem_read(mem_read), .i_mem_write(mem_write),
        .i_mem_burst_begin(mem_bb), .i_mem_size(mem_size), .i_mem_addr(mem_addr),
        .i_mem_rdata_valid(rdata_valid));

    // DDR2 pair on the same requests, own valid
    pmb_if link2();
    pmb_requester #(.P_DDR3(1'b0)) i_pmb_requester_ddr2 (.i_clk(i_clk), .i_reset(i_reset),
        .link(link2), .i_req_valid(req2_valid), .i_req_write(req_write), .i_req_addr(req_addr),
        .i_req_data(req_data), .o_req_ready(req2_ready), .o_rd_valid(rd2_valid),
        .o_rd_data(rd2_data), .i_rd_ready(rd_ready));
    pmb_bridge #(.P_DDR3(1'b0)) i_pmb_bridge_ddr2 (.i_clk(i_clk), .i_reset(i_reset),
        .link(link2), .i_mem_ready(mem_ready), .o_mem_read(mem2_read),
        .o_mem_write(mem2_write), .o_mem_burst_begin(mem2_bb), .o_mem_size(mem2_size),
        .o_mem_addr(mem2_addr), .o_mem_wdata(mem2_wdata), .i_mem_rdata_valid(rdata2_valid),
        .i_mem_rdata(rdata2));

    // clock and hang guard
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            report_and_stop();
        end
    end

    // one DDR3 burst is two local words
    always @(negedge i_clk)
    begin
        if (mem_write && mem_bb)
        begin
            mem[mem_addr] = mem_wdata;
            waddr = mem_addr;
        end
        else if (mem_write)
            mem[waddr + 24'h1] = mem_wdata;
        if (mem_read)
        begin
            raddr = mem_addr;
            rq.push_back(mem[mem_addr]);
            rq.push_back(mem[mem_addr + 24'h1]);
        end
        if (rd_valid && rd_ready)
            got.push_back(rd_data);
        // one DDR2 burst is one local word
        if (mem2_write && mem2_bb)
            mem2[mem2_addr] = mem2_wdata;
        if (mem2_write)
            wcnt2++;
        if (mem2_read)
            rq2.push_back(mem2[mem2_addr]);
        if (rd2_valid && rd_ready)
            got2.push_back(rd2_data);
    end

    // returns one word a cycle, scrambled data when idle
    always @(posedge i_clk)
    begin
        #1;
        rdata_valid = rq.size() > 0;
        rdata = (rq.size() > 0) ? rq.pop_front() : ~rdata;
        rdata2_valid = rq2.size() > 0;
        rdata2 = (rq2.size() > 0) ? rq2.pop_front() : ~rdata2;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask

    // each pair keeps its valid up until it has taken the request
    task automatic send(input logic w, input logic [23:0] a, input logic [127:0] d);
        logic [1:0] left;
        left = 2'h3;
        req_write = w;
        req_addr = a;
        req_data = d;
        for (int i = 0; i < 50 && left != 2'h0; i++)
        begin
            {req2_valid, req_valid} = left;
            @(negedge i_clk);
            left = left & ~{req2_ready, req_ready};
            tick();
        end
        check(left, 256'h0);
    endtask

    task automatic wait_got(input int n);
        for (int i = 0; i < 80 && (got.size() < n || got2.size() < n / 2); i++)
            tick();
    endtask

    task automatic check_pair(input logic [127:0] w);
        check(got.pop_front(), {w + 128'h1, w});
        check(got.pop_front(), {w + 128'h3, w + 128'h2});
        check(got2.pop_front(), {w + 128'h1, w});
    endtask

    // both pairs empty and idle after reset
    task automatic check_idle();
        check({link.cmd_ready, link.wd_ready, rd_valid}, 256'h6);
        check({mem_write, mem_read, mem_size}, 256'h2);
        check({link2.cmd_ready, link2.wd_ready, rd2_valid}, 256'h6);
        check({mem2_write, mem2_read, mem2_size}, 256'h1);
    endtask

    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        check_idle();
        // write group then read back, back to back
        foreach (rows[r])
        begin
            for (int k = 0; k < 4; k++)
                send(1'b1, rows[r].addr + 24'(k), rows[r].w0 + 128'(k));
            send(1'b0, rows[r].addr, 128'h0);
            {req2_valid, req_valid} = 2'h0;
            wait_got(2);
            check(waddr, rows[r].laddr);
            check(raddr, rows[r].laddr);
            check_pair(rows[r].w0);
            $display("row %0d done", r);
        end
        // one single-beat DDR2 write per pair of words
        check(wcnt2, 256'h6);
        // controller and reader both stalled
        mem_ready = 1'b0;
        rd_ready = 1'b0;
        send(1'b0, 24'h4, 128'h0);
        send(1'b0, 24'h0, 128'h0);
        {req2_valid, req_valid} = 2'h0;
        repeat (10) tick();
        check(raddr, 24'h7FFFFE);
        check({mem_read, mem2_read}, 256'h0);
        mem_ready = 1'b1;
        repeat (20) tick();
        check({rd_valid, rd2_valid}, 256'h3);
        rd_ready = 1'b1;
        wait_got(4);
        check_pair(rows[1].w0);
        check_pair(rows[0].w0);
        $display("stall test done");
        // reset in mid group
        send(1'b1, 24'h8, 128'h5);
        send(1'b1, 24'h9, 128'h6);
        {req2_valid, req_valid} = 2'h0;
        tick();
        i_reset = 1'b1;
        repeat (3) tick();
        i_reset = 1'b0;
        check_idle();
        check(mem.exists(24'h4), 1'b0);
        check(mem2.exists(24'h4), 1'b0);
        send(1'b0, 24'h0, 128'h0);
        {req2_valid, req_valid} = 2'h0;
        wait_got(2);
        check_pair(rows[0].w0);
        $display("reset test done");
        report_and_stop();
    end
endmodule
